// >>> design/simd_pkg.sv
// Package: register map, field layout, opcodes and mode encodings
`default_nettype none
package simd_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets (APB, aligned 32-bit words; wide registers span several)
  // ------------------------------------------------------------------
  localparam logic [11:0] OFF_CMD     = 12'h000;
  localparam logic [11:0] OFF_CFG     = 12'h004;
  localparam logic [11:0] OFF_MEMADDR = 12'h008;
  localparam logic [11:0] OFF_STATUS  = 12'h00C;
  localparam logic [11:0] OFF_DST     = 12'h010; // Four words, lane 0 low
  localparam logic [11:0] OFF_SRC     = 12'h020;
  localparam logic [11:0] OFF_MASK    = 12'h030;
  localparam logic [11:0] OFF_GPR     = 12'h040; // Two words, low first
  localparam logic [11:0] OFF_RES     = 12'h050;
  localparam logic [11:0] OFF_SRES    = 12'h060;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int CMD_OP_LSB     = 0;
  localparam int CMD_IMM_LSB    = 8;
  localparam int CFG_MODE_LSB   = 0;
  localparam int CFG_PMASK_BIT  = 2;
  localparam int CFG_ALIGN_BIT  = 3;
  localparam int MEM_FLAG_BIT   = 4;
  localparam int ST_DONE        = 0;
  localparam int ST_INVALID     = 1;
  localparam int ST_PREC        = 2;
  localparam int ST_ALIGN       = 3;
  localparam int ST_PREC_TRAP   = 4;
  localparam int ST_BADOP       = 5;
  localparam int ST_BUSY        = 8;
  localparam int IMM_USE_GLOBAL = 2;
  localparam int IMM_NO_PREC    = 3;
  localparam int IMM_INS_DST    = 4;
  localparam int IMM_INS_SRC    = 6;
  localparam logic [3:0] CFG_RST = 4'h4; // Nearest, precision masked

  // ------------------------------------------------------------------
  // Rounding modes, opcodes, execution states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    RM_NEAREST = 2'h0, RM_DOWN = 2'h1, RM_UP = 2'h2, RM_TRUNC = 2'h3
  } rmode_t;

  typedef enum logic [4:0] {
    OP_BLEND_SI = 5'h00, OP_BLEND_DI = 5'h01, OP_BLEND_WI = 5'h02,
    OP_BLEND_SM = 5'h03, OP_BLEND_DM = 5'h04, OP_BLEND_BM = 5'h05,
    OP_MINUW    = 5'h06, OP_MAXUW    = 5'h07, OP_MINUD    = 5'h08,
    OP_MAXUD    = 5'h09, OP_MINSB    = 5'h0A, OP_MAXSB    = 5'h0B,
    OP_MINSD    = 5'h0C, OP_MAXSD    = 5'h0D, OP_RND_PS   = 5'h0E,
    OP_RND_PD   = 5'h0F, OP_RND_SS   = 5'h10, OP_RND_SD   = 5'h11,
    OP_EXT_SL   = 5'h12, OP_INS_SL   = 5'h13, OP_INS_B    = 5'h14,
    OP_INS_D    = 5'h15, OP_INS_Q    = 5'h16, OP_EXT_B    = 5'h17,
    OP_EXT_W    = 5'h18, OP_EXT_D    = 5'h19, OP_EXT_Q    = 5'h1A
  } op_t;

  typedef enum logic {EX_IDLE = 1'b0, EX_RUN = 1'b1} exec_t;

endpackage : simd_pkg
`default_nettype wire

// >>> design/round_if.sv
// Interface between the datapath and its rounding unit
`timescale 1ns/1ns
`default_nettype none
interface round_if;
  logic [127:0] vec_in;
  logic         dbl;
  logic         scalar;
  logic [1:0]   mode;
  logic [127:0] vec_out;
  logic         invalid;
  logic         inexact;
  modport req  (output vec_in, dbl, scalar, mode,
                input  vec_out, invalid, inexact);
  modport unit (input  vec_in, dbl, scalar, mode,
                output vec_out, invalid, inexact);
endinterface : round_if
`default_nettype wire

// >>> design/round_unit.sv
// Rounding unit: floating-point values to integral values, per lane
`timescale 1ns/1ns
`default_nettype none
module round_unit
  import simd_pkg::*;
(
  // Operand and result
  round_if.unit rb
);

  // ------------------------------------------------------------------
  // One lane: returns {invalid, inexact, value}; single sits in [31:0]
  // ------------------------------------------------------------------
  function automatic logic [65:0] rnd(input logic [63:0] x,
                                      input logic dbl,
                                      input logic [1:0] md);
    logic [63:0] mag, fmask, fpart, lsb, half, res, fr;
    logic [10:0] ex;
    logic        sg, up, inv, inx;
    int          mb, bias, e;
    mb    = dbl ? 52 : 23;
    bias  = dbl ? 1023 : 127;
    sg    = dbl ? x[63] : x[31];
    mag   = dbl ? {1'b0, x[62:0]} : {33'h0, x[30:0]};
    ex    = dbl ? x[62:52] : {3'h0, x[30:23]};
    e     = int'(ex) - bias;
    fr    = mag & ((64'h1 << mb) - 64'h1);
    inv   = 1'b0;
    inx   = 1'b0;
    up    = 1'b0;
    res   = mag;
    fmask = 64'h0;
    if (ex == (dbl ? 11'h7FF : 11'h0FF)) begin
      // NaN comes back quiet; only a signalling NaN is invalid
      if (fr != 64'h0) begin
        inv = ~mag[mb-1];
        res = mag | (64'h1 << (mb - 1));
      end
    end else if (e < 0) begin
      // Below one: result is a signed zero or a signed one
      inx = (mag != 64'h0);
      case (rmode_t'(md))
        RM_NEAREST: up = (e == -1) && (fr != 64'h0);
        RM_DOWN:    up = sg && inx;
        RM_UP:      up = ~sg && inx;
        default:    up = 1'b0;
      endcase
      res = up ? (64'(bias) << mb) : 64'h0;
    end else if (e < mb) begin
      fmask = (64'h1 << (mb - e)) - 64'h1;
      fpart = mag & fmask;
      lsb   = 64'h1 << (mb - e);
      half  = lsb >> 1;
      inx   = (fpart != 64'h0);
      case (rmode_t'(md))
        // Ties go to the even neighbour
        RM_NEAREST: up = (fpart > half) ||
                         ((fpart == half) && ((mag & lsb) != 64'h0));
        RM_DOWN:    up = sg && inx;
        RM_UP:      up = ~sg && inx;
        default:    up = 1'b0;
      endcase
      // A carry out of the mantissa bumps the exponent, as it must
      res = (mag & ~fmask) + (up ? lsb : 64'h0);
    end
    return dbl ? {inv, inx, sg, res[62:0]}
               : {inv, inx, 32'h0, sg, res[30:0]};
  endfunction : rnd

  // ------------------------------------------------------------------
  // Lane array; lanes above zero pass through on scalar forms
  // ------------------------------------------------------------------
  always_comb begin
    logic [65:0] r;
    r          = 66'h0;
    rb.vec_out = rb.vec_in;
    rb.invalid = 1'b0;
    rb.inexact = 1'b0;
    if (rb.dbl) begin
      for (int i = 0; i < 2; i++) begin
        if (i == 0 || !rb.scalar) begin
          r = rnd(rb.vec_in[64*i +: 64], 1'b1, rb.mode);
          rb.vec_out[64*i +: 64] = r[63:0];
          rb.invalid = rb.invalid | r[65];
          rb.inexact = rb.inexact | r[64];
        end
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (i == 0 || !rb.scalar) begin
          r = rnd({32'h0, rb.vec_in[32*i +: 32]}, 1'b0, rb.mode);
          rb.vec_out[32*i +: 32] = r[31:0];
          rb.invalid = rb.invalid | r[65];
          rb.inexact = rb.inexact | r[64];
        end
      end
    end
  end

endmodule : round_unit
`default_nettype wire

// >>> design/simd_datapath.sv
// Packed blend, min/max, round and insert/extract datapath behind APB
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module simd_datapath
  import simd_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    op_t          op;
    logic [7:0]   imm;
    logic [3:0]   cfg;
    logic [4:0]   maddr;
    logic [127:0] dst;
    logic [127:0] src;
    logic [127:0] msk;
    logic [63:0]  gpr;
    logic [127:0] res;
    logic [63:0]  sres;
    logic [5:0]   stat;
    exec_t        ex;
    logic         rdy;
    logic         err;
    logic [31:0]  rdata;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  round_if rb ();

  round_unit u_round (
    .rb (rb)
  );

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Expand one select bit per lane into a per-byte select
  function automatic logic [15:0] lane_sel(input logic [15:0] bits,
                                           input int bytes);
    logic [15:0] o;
    o = 16'h0;
    for (int i = 0; i < 16; i++) begin
      o[i] = bits[i / bytes];
    end
    return o;
  endfunction : lane_sel

  // Per-byte merge of source over destination
  function automatic logic [127:0] merge(input logic [127:0] d,
                                         input logic [127:0] s,
                                         input logic [15:0] sel);
    logic [127:0] o;
    o = d;
    for (int i = 0; i < 16; i++) begin
      if (sel[i]) begin
        o[8*i +: 8] = s[8*i +: 8];
      end
    end
    return o;
  endfunction : merge

  // Pick min or max of two lanes held in 33 bits with a sign guard
  function automatic logic [32:0] pick(input logic [32:0] a,
                                       input logic [32:0] b,
                                       input logic mx);
    logic b_lt;
    b_lt = $signed(b) < $signed(a);
    return (b_lt ^ mx) ? b : a;
  endfunction : pick

  // Lane-wise min/max for 1, 2 or 4 byte lanes
  function automatic logic [127:0] minmax(input logic [127:0] a,
                                          input logic [127:0] b,
                                          input int bytes,
                                          input logic sgn,
                                          input logic mx);
    logic [127:0] o;
    logic [32:0]  x, y, r;
    int           w;
    o = 128'h0;
    w = 8 * bytes;
    for (int i = 0; i < 16; i++) begin
      if (i < 16 / bytes) begin
        x = 33'h0;
        y = 33'h0;
        for (int k = 0; k < 33; k++) begin
          if (k < w) begin
            x[k] = a[w*i + k];
            y[k] = b[w*i + k];
          end else begin
            x[k] = sgn & a[w*i + w - 1];
            y[k] = sgn & b[w*i + w - 1];
          end
        end
        r = pick(x, y, mx);
        for (int k = 0; k < 32; k++) begin
          if (k < w) begin
            o[w*i + k] = r[k];
          end
        end
      end
    end
    return o;
  endfunction : minmax

  // Memory operand width in bytes for the insert/extract forms
  function automatic logic [3:0] mem_bytes(input op_t op);
    case (op)
      OP_INS_B, OP_EXT_B:            return 4'h1;
      OP_EXT_W:                      return 4'h2;
      OP_INS_Q, OP_EXT_Q:            return 4'h8;
      OP_EXT_SL, OP_INS_SL,
      OP_INS_D, OP_EXT_D:            return 4'h4;
      default:                       return 4'h0;
    endcase
  endfunction : mem_bytes

  // Replace one 32-bit word of a 128-bit register
  function automatic logic [127:0] put_word(input logic [127:0] v,
                                            input logic [1:0] idx,
                                            input logic [31:0] w);
    logic [127:0] o;
    o = v;
    o[32*idx +: 32] = w;
    return o;
  endfunction : put_word

  // ------------------------------------------------------------------
  // Rounding unit operands
  // ------------------------------------------------------------------
  // immediate field layout
  assign rb.mode   = s_r.imm[IMM_USE_GLOBAL] ?
                     s_r.cfg[CFG_MODE_LSB +: 2] : s_r.imm[1:0];
  assign rb.vec_in = s_r.src;
  assign rb.dbl    = (s_r.op == OP_RND_PD) || (s_r.op == OP_RND_SD);
  assign rb.scalar = (s_r.op == OP_RND_SS) || (s_r.op == OP_RND_SD);

  // ------------------------------------------------------------------
  // Next state: bus access and execution
  // ------------------------------------------------------------------
  always_comb begin
    logic [127:0] r;
    logic [63:0]  sr;
    logic [5:0]   set;
    logic [5:0]   clr;
    logic [31:0]  rd;
    logic [31:0]  ins;
    logic [3:0]   nb;
    logic         map;
    logic         wr;
    logic [1:0]   wi;
    r     = s_r.dst;
    sr    = 64'h0;
    set   = 6'h0;
    clr   = 6'h0;
    rd    = 32'h0;
    ins   = 32'h0;
    nb    = mem_bytes(s_r.op);
    map   = 1'b1;
    wr    = psel && penable && s_r.rdy && pwrite;
    wi    = paddr[3:2];
    s_nxt = s_r;

    // Operation result, latched only in the run state
    case (s_r.op)
      OP_BLEND_SI: r = merge(s_r.dst, s_r.src,
                             lane_sel({12'h0, s_r.imm[3:0]}, 4));
      OP_BLEND_DI: r = merge(s_r.dst, s_r.src,
                             lane_sel({14'h0, s_r.imm[1:0]}, 8));
      OP_BLEND_WI: r = merge(s_r.dst, s_r.src,
                             lane_sel({8'h0, s_r.imm}, 2));
      OP_BLEND_SM: r = merge(s_r.dst, s_r.src, lane_sel({12'h0,
                     s_r.msk[127], s_r.msk[95], s_r.msk[63],
                     s_r.msk[31]}, 4));
      OP_BLEND_DM: r = merge(s_r.dst, s_r.src,
                     lane_sel({14'h0, s_r.msk[127], s_r.msk[63]}, 8));
      OP_BLEND_BM: begin
        for (int i = 0; i < 16; i++) begin
          ins[i] = s_r.msk[8*i + 7];
        end
        r = merge(s_r.dst, s_r.src, ins[15:0]);
      end
      OP_MINUW: r = minmax(s_r.dst, s_r.src, 2, 1'b0, 1'b0);
      OP_MAXUW: r = minmax(s_r.dst, s_r.src, 2, 1'b0, 1'b1);
      OP_MINUD: r = minmax(s_r.dst, s_r.src, 4, 1'b0, 1'b0);
      OP_MAXUD: r = minmax(s_r.dst, s_r.src, 4, 1'b0, 1'b1);
      OP_MINSD: r = minmax(s_r.dst, s_r.src, 4, 1'b1, 1'b0);
      OP_MAXSD: r = minmax(s_r.dst, s_r.src, 4, 1'b1, 1'b1);
      OP_MINSB: r = minmax(s_r.dst, s_r.src, 1, 1'b1, 1'b0);
      OP_MAXSB: r = minmax(s_r.dst, s_r.src, 1, 1'b1, 1'b1);
      OP_RND_PS, OP_RND_PD: r = rb.vec_out;
      OP_RND_SS: r = {s_r.dst[127:32], rb.vec_out[31:0]};
      OP_RND_SD: r = {s_r.dst[127:64], rb.vec_out[63:0]};
      OP_EXT_SL: sr = {32'h0, s_r.dst[32*s_r.imm[1:0] +: 32]};
      OP_INS_SL: begin
        ins = s_r.maddr[MEM_FLAG_BIT] ? s_r.gpr[31:0] :
              s_r.src[32*s_r.imm[IMM_INS_SRC +: 2] +: 32];
        r   = put_word(s_r.dst, s_r.imm[IMM_INS_DST +: 2], ins);
        for (int i = 0; i < 4; i++) begin
          if (s_r.imm[i]) begin
            r[32*i +: 32] = 32'h0;
          end
        end
      end
      OP_INS_B: r[8*s_r.imm[3:0] +: 8]  = s_r.gpr[7:0];
      OP_INS_D: r[32*s_r.imm[1:0] +: 32] = s_r.gpr[31:0];
      OP_INS_Q: r[64*s_r.imm[0] +: 64]   = s_r.gpr;
      OP_EXT_B: sr = {56'h0, s_r.dst[8*s_r.imm[3:0] +: 8]};
      OP_EXT_W: sr = {48'h0, s_r.dst[16*s_r.imm[2:0] +: 16]};
      OP_EXT_D: sr = {32'h0, s_r.dst[32*s_r.imm[1:0] +: 32]};
      OP_EXT_Q: sr = s_r.dst[64*s_r.imm[0] +: 64];
      default:  set[ST_BADOP] = 1'b1;
    endcase

    // only invalid, precision and precision trap, from rounds alone
    if (s_r.op inside {OP_RND_PS, OP_RND_PD, OP_RND_SS, OP_RND_SD}) begin
      set[ST_INVALID] = rb.invalid;
      set[ST_PREC]      = rb.inexact && !s_r.imm[IMM_NO_PREC];
      set[ST_PREC_TRAP] = set[ST_PREC] && !s_r.cfg[CFG_PMASK_BIT];
    end

    // misaligned memory operand faults only under checking
    if (s_r.cfg[CFG_ALIGN_BIT] && s_r.maddr[MEM_FLAG_BIT] && nb != 4'h0
        && ((s_r.maddr[3:0] & (nb - 4'h1)) != 4'h0)) begin
      set[ST_ALIGN] = 1'b1;
    end

    // Run state: commit result unless the operand faulted or the opcode is unknown
    case (s_r.ex)
      EX_RUN: begin
        set[ST_DONE] = 1'b1;
        if (!set[ST_ALIGN] && !set[ST_BADOP]) begin
          s_nxt.res  = r;
          s_nxt.sres = sr;
        end
        s_nxt.ex = EX_IDLE;
      end
      default: s_nxt.ex = EX_IDLE;
    endcase
    if (!(s_r.ex == EX_RUN)) begin
      set = 6'h0;
    end

    // Register writes at the access edge
    if (wr) begin
      case (paddr[11:4])
        8'h00: begin
          case (wi)
            2'h0: begin
              s_nxt.op  = op_t'(pwdata[CMD_OP_LSB +: 5]);
              s_nxt.imm = pwdata[CMD_IMM_LSB +: 8];
              s_nxt.ex  = EX_RUN;
            end
            2'h1:    s_nxt.cfg   = pwdata[3:0];
            2'h2:    s_nxt.maddr = pwdata[4:0];
            default: clr         = pwdata[5:0];
          endcase
        end
        8'h01: s_nxt.dst = put_word(s_r.dst, wi, pwdata);
        8'h02: s_nxt.src = put_word(s_r.src, wi, pwdata);
        8'h03: s_nxt.msk = put_word(s_r.msk, wi, pwdata);
        8'h04: begin
          if (wi == 2'h0) begin
            s_nxt.gpr[31:0] = pwdata;
          end else if (wi == 2'h1) begin
            s_nxt.gpr[63:32] = pwdata;
          end
        end
        default: ;
      endcase
    end
    // Sticky status: a set in the clearing cycle wins
    s_nxt.stat = (s_r.stat & ~clr) | set;

    // Read mux and decode, prepared in the setup cycle
    case (paddr[11:4])
      8'h00: begin
        case (wi)
          2'h0:    rd = {16'h0, s_r.imm, 3'h0, s_r.op};
          2'h1:    rd = {28'h0, s_r.cfg};
          2'h2:    rd = {27'h0, s_r.maddr};
          default: rd = {23'h0, s_r.ex == EX_RUN, 2'h0, s_r.stat};
        endcase
      end
      8'h01: rd = s_r.dst[32*wi +: 32];
      8'h02: rd = s_r.src[32*wi +: 32];
      8'h03: rd = s_r.msk[32*wi +: 32];
      8'h04: begin
        map = !wi[1];
        rd  = wi[1] ? 32'h0 : s_r.gpr[32*wi[0] +: 32];
      end
      8'h05: rd = s_r.res[32*wi +: 32];
      8'h06: begin
        map = !wi[1];
        rd  = wi[1] ? 32'h0 : s_r.sres[32*wi[0] +: 32];
      end
      default: map = 1'b0;
    endcase

    // One wait-free access phase: ready rises at the edge that ends the setup cycle
    s_nxt.rdy   = psel && !penable && !s_r.rdy;
    s_nxt.err   = s_nxt.rdy && !map;
    s_nxt.rdata = (s_nxt.rdy && !pwrite && map) ? rd : 32'h0;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r     <= '0;
      s_r.cfg <= CFG_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Bus outputs straight from the state register
  assign pready  = s_r.rdy;
  assign pslverr = s_r.err;
  assign prdata  = s_r.rdata;

endmodule : simd_datapath
`default_nettype wire

// >>> verif/simd_datapath_sva.sv
// Checker on the APB ports of the packed SIMD datapath
`timescale 1ns/1ns
`default_nettype none
module simd_datapath_sva
  import simd_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr
);
  // ----------------------------------------------------------------
  // Last command, so that a status read can be judged by its cause
  // ----------------------------------------------------------------
  logic [4:0] op_r;
  logic       quiet_r;
  logic       cmd_w;
  assign cmd_w = psel && penable && pready && pwrite && paddr == OFF_CMD;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r    <= 5'h00;
      quiet_r <= 1'b0;
    end else if (cmd_w) begin
      op_r    <= pwdata[4:0];
      quiet_r <= pwdata[11];
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_stat;
    s_setup ##0 (!pwrite && paddr == OFF_STATUS);
  endsequence
  property p_ready;
    s_setup |=> pready;
  endproperty
  property p_pulse;
    pready |=> !pready;
  endproperty
  property p_idle;
    !pready |-> prdata == 32'h0 && !pslverr;
  endproperty
  property p_unmap;
    s_setup ##0 paddr >= 12'h070 |=> pslverr && prdata == 32'h0;
  endproperty
  property p_busy;
    s_stat |=> prdata[ST_BUSY] == $past(cmd_w, 2);
  endproperty
  property p_nonum;
    s_stat ##0 (op_r < 5'h06 || op_r == OP_EXT_SL || op_r == OP_INS_SL)
      |=> prdata[2:1] == 2'h0;
  endproperty
  property p_quiet;
    s_stat ##0 (quiet_r && op_r inside {[5'h0E:5'h11]})
      |=> !prdata[ST_PREC] && !prdata[ST_PREC_TRAP];
  endproperty
  property p_badop;
    s_stat ##0 op_r > 5'h1A |=> prdata[ST_BADOP];
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  a_idle: assert property (p_idle) else $error("read data outside access");
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  a_busy: assert property (p_busy) else $error("busy bit wrong");
  a_nonum: assert property (p_nonum) else $error("numeric flag set");
  a_quiet: assert property (p_quiet) else $error("precision flagged");
  a_badop: assert property (p_badop) else $error("bad opcode not flagged");
endmodule : simd_datapath_sva
bind simd_datapath simd_datapath_sva sva_u (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);
`default_nettype wire

// >>> verif/apb_host.sv
// APB master model for the decode and register-file side of the block
`timescale 1ns/1ns
`default_nettype none
module apb_host (
  // Clock and answer
  input  wire logic        pclk,
  input  wire logic        pready,
  // Request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  // Bus idle from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
  end
  // One transfer; entered just after an edge, one idle edge after it
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] v);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
endmodule : apb_host
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the packed SIMD datapath
`timescale 1ns/1ns
`default_nettype none
module tb;
  import simd_pkg::*;
  typedef struct {logic [31:0] m; logic [32:0] v;} note_t;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata;
  logic [127:0] d, s, m, e, x, y, mk, f;
  logic [63:0]  g;
  logic [7:0]   imm;
  int           num_errors, checks, sz, l;
  int           wd[7] = '{1, 4, 8, 1, 2, 4, 8};
  note_t        notes[$], nt;
  simd_datapath dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
                       .pwdata, .pready, .prdata, .pslverr);
  apb_host host_u (.pclk, .pready, .psel, .penable, .pwrite, .paddr, .pwdata);
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    host_u.xfer(1'b1, a, v);
  endtask : wr
  // Note the expectation first, the monitor pops it at the answer
  task automatic rd(input logic [11:0] a, input logic [32:0] v,
                    input logic [31:0] k = 32'hFFFFFFFF);
    notes.push_back('{k, v});
    host_u.xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic wr128(input logic [11:0] a, input logic [127:0] v);
    for (int k = 0; k < 4; k++) wr(a + 12'(4 * k), v[32*k+:32]);
  endtask : wr128
  task automatic rd128(input logic [127:0] v);
    for (int k = 0; k < 4; k++) rd(OFF_RES + 12'(4 * k), {1'b0, v[32*k+:32]});
  endtask : rd128
  // Flags are cleared first so each status read reflects one command
  task automatic run(input logic [4:0] op, input logic [7:0] i);
    wr(OFF_STATUS, 32'hFF);
    wr(OFF_CMD, {16'h0, i, 3'h0, op});
  endtask : run
  task automatic give_verdict;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  function automatic logic [127:0] rnd;
    return {$urandom, $urandom, $urandom, $urandom};
  endfunction : rnd
  // ----------------------------------------------------------------
  // Clock, monitor, watchdog
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      nt = notes.pop_front();
      chk({pslverr, prdata & nt.m}, nt.v);
    end
  end
  initial begin
    #300000;
    num_errors++;
    give_verdict();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    void'($urandom(53444));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_CFG, 33'h4);
    rd(OFF_STATUS, 33'h0);
    rd(12'h0F0, 33'h100000000);
    d = rnd();
    s = rnd();
    m = rnd();
    g = {$urandom, $urandom};
    wr128(OFF_DST, d);
    wr128(OFF_SRC, s);
    wr128(OFF_MASK, m);
    wr(OFF_GPR, g[31:0]);
    wr(OFF_GPR + 12'h4, g[63:32]);
    for (int i = 0; i < 6; i++) begin
      sz = (i == 1 || i == 4) ? 8 : (i == 2) ? 2 : (i == 5) ? 1 : 4;
      imm = 8'($urandom);
      for (int b = 0; b < 16; b++) begin
        l = b / sz;
        e[8*b+:8] = ((i<3) ? imm[l] : m[(l+1)*sz*8-1]) ? s[8*b+:8] : d[8*b+:8];
      end
      run(5'(i), imm);
      rd128(e);
    end
    // min and max; sign bit flip turns signed into unsigned
    for (int o = 6; o < 14; o++) begin
      sz = (o < 8) ? 2 : (o == 10 || o == 11) ? 1 : 4;
      mk = (128'h1 << (sz * 8)) - 128'h1;
      f = (o > 9) ? 128'h1 << (sz * 8 - 1) : 128'h0;
      e = '0;
      for (int k = 0; k < 16 / sz; k++) begin
        x = (d >> (k * sz * 8)) & mk;
        y = (s >> (k * sz * 8)) & mk;
        e |= ((o[0] ^ ((x ^ f) < (y ^ f))) ? x : y) << (k * sz * 8);
      end
      run(5'(o), 8'h00);
      rd128(e);
    end
    // insert lane 2 into lane 1, zero lane 3
    e = d;
    e[63:32] = s[95:64];
    e[127:96] = 32'h0;
    run(OP_INS_SL, 8'h98);
    rd128(e);
    rd(OFF_STATUS, 33'h1);
    // misaligned memory word, accepted then refused
    wr(OFF_MEMADDR, 32'h11);
    run(OP_INS_SL, 8'h30);
    e = d;
    e[127:96] = g[31:0];
    rd128(e);
    wr(OFF_CFG, 32'hC);
    run(OP_INS_SL, 8'h00);
    rd128(e);
    rd(OFF_STATUS, 33'h8, 32'h8);
    wr(OFF_CFG, 32'h4);
    wr(OFF_MEMADDR, 32'h0);
    // extract source equals destination, so unambiguous
    wr128(OFF_SRC, d);
    run(OP_EXT_SL, 8'h03);
    rd(OFF_SRES, {1'b0, d[127:96]});
    for (int i = 0; i < 7; i++) begin
      sz = wd[i];
      l = $urandom_range(16 / sz - 1);
      mk = (128'h1 << (sz * 8)) - 128'h1;
      run(5'(20 + i), 8'(l));
      if (i < 3) begin
        rd128((d & ~(mk << (l*sz*8))) | ((g & mk) << (l*sz*8)));
      end else begin
        e = (d >> (l * sz * 8)) & mk;
        rd(OFF_SRES, {1'b0, e[31:0]});
        rd(OFF_SRES + 12'h4, {1'b0, e[63:32]});
      end
    end
    // four modes, then the global one
    wr(OFF_CFG, 32'h5);
    wr128(OFF_SRC, 128'h00000000_7F800001_BFC00000_3FC00000);
    for (int md = 0; md < 5; md++) begin
      imm = (md == 4) ? 8'h04 : 8'(md + 8 * (md % 2));
      l = (md == 4) ? 1 : md;
      run(OP_RND_PS, imm);
      rd128({32'h0, 32'h7FC00001, l[1] ? 32'hBF800000 : 32'hC0000000,
             l[0] ? 32'h3F800000 : 32'h40000000});
      rd(OFF_STATUS, {30'h0, !imm[3], 2'h3});
    end
    rd(OFF_CFG, 33'h5);
    wr(OFF_CFG, 32'h0);
    run(OP_RND_SD, 8'h00);
    rd128({d[127:64], 64'h8000000000000000});
    rd(OFF_STATUS, 33'h15);
    run(OP_RND_SS, 8'h00);
    rd128({d[127:32], 32'h40000000});
    run(OP_RND_PD, 8'h08);
    rd128({64'h0, 64'h8000000000000000});
    rd(OFF_STATUS, 33'h1);
    run(5'h1B, 8'h00);
    rd(OFF_STATUS, 33'h20, 32'h20);
    @(posedge pclk);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
